// ---- rtl/rxdt_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "rxdt_regs.vh"
module rxdt_top #(
    parameter NCH          = 8,
    parameter TEST_TICKS   = `RXDT_TEST_MS * 1000 / `RXDT_TICK_US,
    parameter GIVEUP_TICKS = `RXDT_GIVEUP_MS * 1000 / `RXDT_TICK_US,
    parameter PD_CYCLES    = (`RXDT_PD_RESET_NS * `RXDT_CLK_MHZ + 999) / 1000,
    parameter TICK_CYCLES  = `RXDT_TICK_US * `RXDT_CLK_MHZ
) (
    // clock and reset
    input  wire           clock_i,
    input  wire           sys_rst_i,
    // configuration pins
    input  wire           power_down_pin_i,
    input  wire           management_enable_pin_i,
    input  wire [1:0]     receiver_detect_select_i,
    input  wire [1:0]     signal_detect_threshold_select_i,
    // analog front end
    input  wire [NCH-1:0] partner_present_i,
    output reg  [NCH-1:0] term50_o,
    output reg  [NCH-1:0] probe_o,
    output reg            drivers_enable_o,
    output reg  [1:0]     threshold_code_o,
    output reg  [NCH-1:0] sd_force_o,
    // axi4-lite write address
    input  wire [7:0]     s_axi_awaddr,
    input  wire           s_axi_awvalid,
    output reg            s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]    s_axi_wdata,
    input  wire [3:0]     s_axi_wstrb,
    input  wire           s_axi_wvalid,
    output reg            s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]     s_axi_bresp,
    output reg            s_axi_bvalid,
    input  wire           s_axi_bready,
    // axi4-lite read
    input  wire [7:0]     s_axi_araddr,
    input  wire           s_axi_arvalid,
    output reg            s_axi_arready,
    output reg  [31:0]    s_axi_rdata,
    output reg  [1:0]     s_axi_rresp,
    output reg            s_axi_rvalid,
    input  wire           s_axi_rready
);
    // pin synchronisers
    wire       pd_s;
    wire       men_s;
    wire [1:0] rxsel_s;
    wire [1:0] thsel_s;
    wire [NCH-1:0] pres_s;
    rxdt_sync #(.W(6 + NCH)) u_sync (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .d_i       ({power_down_pin_i, management_enable_pin_i, receiver_detect_select_i,
                     signal_detect_threshold_select_i, partner_present_i}),
        .q_o       ({pd_s, men_s, rxsel_s, thsel_s, pres_s})
    );

    // registers
    reg [1:0]     ctrl_r;
    reg [1:0]     receiver_detect_select_r;
    reg [1:0]     thresh_r;
    reg [NCH-1:0] sdforce_r;

    // timebase tick
    reg [15:0] tick_cnt_r;
    reg        tick_r;
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == TICK_CYCLES[15:0] - 16'h0001);
            if (tick_cnt_r == TICK_CYCLES[15:0] - 16'h0001)
                tick_cnt_r <= 16'h0000;
            else
                tick_cnt_r <= tick_cnt_r + 16'h0001;
        end
    end

    // power-down hold timer
    reg [15:0] pd_cnt_r;
    reg        sm_reset_r;
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pd_cnt_r   <= 16'h0000;
            sm_reset_r <= 1'b1;
        end else if (!pd_s) begin
            pd_cnt_r   <= 16'h0000;
            sm_reset_r <= 1'b0;
        end else if (pd_cnt_r >= PD_CYCLES[15:0] - 16'h0001) begin
            sm_reset_r <= 1'b1;
        end else begin
            pd_cnt_r <= pd_cnt_r + 16'h0001;
        end
    end

    reg [1:0] th_pin_code;
    always @* begin
        case (thsel_s)
            `RXDT_LVL_LOW:   th_pin_code = 2'h2;
            `RXDT_LVL_RES:   th_pin_code = 2'h1;
            `RXDT_LVL_FLOAT: th_pin_code = 2'h0;
            default:         th_pin_code = 2'h3;
        endcase
    end

    wire [1:0] rxsel_eff = (men_s && ctrl_r[`RXDT_CTRL_RECEIVER_DETECT_SELECT_OVR]) ? receiver_detect_select_r : rxsel_s;
    wire [1:0] th_eff    = (men_s && ctrl_r[`RXDT_CTRL_TH_OVR]) ? thresh_r : th_pin_code;

    wire [NCH-1:0] det_w;
    wire [NCH-1:0] gave_w;
    wire [NCH-1:0] term_w;
    wire [NCH-1:0] probe_w;
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            rxdt_chan #(
                .TEST_TICKS   (TEST_TICKS),
                .GIVEUP_TICKS (GIVEUP_TICKS)
            ) u_ch (
                .clock_i           (clock_i),
                .sys_rst_i         (sys_rst_i),
                .tick_i            (tick_r),
                .sm_reset_i        (sm_reset_r),
                .power_down_i      (pd_s),
                .sel_i             (rxsel_eff),
                .partner_present_i (pres_s[g]),
                .probe_o           (probe_w[g]),
                .detected_o        (det_w[g]),
                .gave_up_o         (gave_w[g]),
                .term50_o          (term_w[g])
            );
        end
    endgenerate

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            term50_o         <= {NCH{1'b0}};
            probe_o          <= {NCH{1'b0}};
            drivers_enable_o <= 1'b0;
            threshold_code_o <= `RXDT_THRESH_RST;
            sd_force_o       <= {NCH{1'b0}};
        end else begin
            term50_o         <= term_w;
            probe_o          <= probe_w;
            drivers_enable_o <= !pd_s;
            threshold_code_o <= th_eff;
            sd_force_o       <= men_s ? sdforce_r : {NCH{1'b0}};
        end
    end

    // write channel: take address and data in either order
    reg [7:0]  aw_addr_r;
    reg        aw_have_r;
    reg [31:0] w_data_r;
    reg        w_have_r;
    wire       wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aw_addr_r     <= 8'h00;
            aw_have_r     <= 1'b0;
            w_data_r      <= 32'h0000_0000;
            w_have_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            ctrl_r        <= `RXDT_CTRL_RST;
            receiver_detect_select_r       <= `RXDT_RECEIVER_DETECT_SELECT_RST;
            thresh_r      <= `RXDT_THRESH_RST;
            sdforce_r     <= `RXDT_SDFORCE_RST;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready;
            s_axi_wready  <= !w_have_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r     <= s_axi_awaddr;
                aw_have_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r     <= s_axi_wdata;
                w_have_r     <= 1'b1;
                s_axi_wready <= 1'b0;
                if (!s_axi_wstrb[0])
                    w_data_r[7:0] <= 8'h00;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                case (aw_addr_r)
                    `RXDT_ADDR_CTRL:    ctrl_r    <= w_data_r[1:0];
                    `RXDT_ADDR_RECEIVER_DETECT_SELECT:   receiver_detect_select_r   <= w_data_r[1:0];
                    `RXDT_ADDR_THRESH:  thresh_r  <= w_data_r[1:0];
                    `RXDT_ADDR_SDFORCE: sdforce_r <= w_data_r[NCH-1:0];
                    `RXDT_ADDR_STATUS:  s_axi_bresp <= 2'h0;
                    `RXDT_ADDR_TERM:    s_axi_bresp <= 2'h0;
                    default:            s_axi_bresp <= 2'h2;
                endcase
            end
            if (!men_s) begin
                ctrl_r    <= `RXDT_CTRL_RST;
                receiver_detect_select_r   <= `RXDT_RECEIVER_DETECT_SELECT_RST;
                thresh_r  <= `RXDT_THRESH_RST;
                sdforce_r <= `RXDT_SDFORCE_RST;
            end
        end
    end

    // read channel, one cycle latency
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'h0;
                s_axi_rdata   <= 32'h0000_0000;
                case (s_axi_araddr)
                    `RXDT_ADDR_CTRL:    s_axi_rdata[1:0]     <= ctrl_r;
                    `RXDT_ADDR_RECEIVER_DETECT_SELECT:   s_axi_rdata[1:0]     <= receiver_detect_select_r;
                    `RXDT_ADDR_THRESH:  s_axi_rdata[1:0]     <= thresh_r;
                    `RXDT_ADDR_SDFORCE: s_axi_rdata[NCH-1:0] <= sdforce_r;
                    `RXDT_ADDR_STATUS:  s_axi_rdata[15:0]    <= {gave_w, det_w};
                    `RXDT_ADDR_TERM:    s_axi_rdata[NCH+2:0] <= {rxsel_eff, pd_s, term_w};
                    default:            s_axi_rresp          <= 2'h2;
                endcase
            end
        end
    end
endmodule // rxdt_top
`default_nettype wire

// ---- pkg/rxdt_regs.vh ----
// Function
// - select 00: input hi-z, no detection
// - select 01: test every 12ms, stop 600ms
// - select 10: test every 12ms until found
// - auto modes: hi-z until detect, then 50 ohm
// - select 11: 50 ohm immediately, no detection
// - power-down: inputs hi-z, outputs disabled
// - power-down held 5us resets detect machine
// - signal detect may be forced on by register
// - separate force control for each channel
// - pins rule unless register override bit set
// - registers default at reset or management low
`ifndef RXDT_REGS_VH
`define RXDT_REGS_VH

// register byte addresses
`define RXDT_ADDR_CTRL      8'h00
`define RXDT_ADDR_RECEIVER_DETECT_SELECT     8'h04
`define RXDT_ADDR_THRESH    8'h08
`define RXDT_ADDR_SDFORCE   8'h0C
`define RXDT_ADDR_STATUS    8'h10
`define RXDT_ADDR_TERM      8'h14

// control register fields
`define RXDT_CTRL_RECEIVER_DETECT_SELECT_OVR 0
`define RXDT_CTRL_TH_OVR    1

// reset values
`define RXDT_CTRL_RST       2'h0
`define RXDT_RECEIVER_DETECT_SELECT_RST      2'h2
`define RXDT_THRESH_RST     2'h0
`define RXDT_SDFORCE_RST    8'h00

// select codes
`define RXDT_SEL_HIZ        2'h0
`define RXDT_SEL_AUTO_LIM   2'h1
`define RXDT_SEL_AUTO_INF   2'h2
`define RXDT_SEL_TERM50     2'h3

// four-level pin encodings
`define RXDT_LVL_LOW        2'h0
`define RXDT_LVL_RES        2'h1
`define RXDT_LVL_FLOAT      2'h2
`define RXDT_LVL_HIGH       2'h3

// timing
`define RXDT_CLK_MHZ        250
`define RXDT_PD_RESET_NS    5000
`define RXDT_TEST_MS        12
`define RXDT_GIVEUP_MS      600
`define RXDT_TICK_US        1

`endif

// ---- rtl/rxdt_sync.v ----
`timescale 1ns/1ps
`default_nettype none
module rxdt_sync #(
    parameter W = 1
) (
    input  wire         clock_i,
    input  wire         sys_rst_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end
    assign q_o = sync_r;
endmodule // rxdt_sync
`default_nettype wire

// ---- rtl/rxdt_chan.v ----
`timescale 1ns/1ps
`default_nettype none
`include "rxdt_regs.vh"
// one channel's detect state machine
module rxdt_chan #(
    parameter TEST_TICKS   = 12000,
    parameter GIVEUP_TICKS = 600000
) (
    input  wire       clock_i,
    input  wire       sys_rst_i,
    input  wire       tick_i,
    input  wire       sm_reset_i,
    input  wire       power_down_i,
    input  wire [1:0] sel_i,
    input  wire       partner_present_i,
    output reg        probe_o,
    output reg        detected_o,
    output reg        gave_up_o,
    output reg        term50_o
);
    reg [19:0] interval_r;
    reg [19:0] total_r;
    reg [1:0]  sel_last_r;
    wire       is_auto = (sel_i == `RXDT_SEL_AUTO_LIM) || (sel_i == `RXDT_SEL_AUTO_INF);
    wire       sel_chg = (sel_i != sel_last_r);

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            interval_r <= 20'h0_0000;
            total_r    <= 20'h0_0000;
            sel_last_r <= `RXDT_SEL_AUTO_INF;
            probe_o    <= 1'b0;
            detected_o <= 1'b0;
            gave_up_o  <= 1'b0;
            term50_o   <= 1'b0;
        end else begin
            sel_last_r <= sel_i;
            probe_o    <= 1'b0;
            if (sm_reset_i || sel_chg || !is_auto) begin
                interval_r <= 20'h0_0000;
                total_r    <= 20'h0_0000;
                detected_o <= 1'b0;
                gave_up_o  <= 1'b0;
            end else if (!power_down_i && !detected_o && !gave_up_o && tick_i) begin
                if (sel_i == `RXDT_SEL_AUTO_LIM && total_r >= GIVEUP_TICKS[19:0] - 20'h0_0001)
                    gave_up_o <= 1'b1;
                else
                    total_r <= total_r + 20'h0_0001;
                if (interval_r >= TEST_TICKS[19:0] - 20'h0_0001) begin
                    interval_r <= 20'h0_0000;
                    probe_o    <= 1'b1;
                    if (partner_present_i)
                        detected_o <= 1'b1;
                end else begin
                    interval_r <= interval_r + 20'h0_0001;
                end
            end
            if (power_down_i)
                term50_o <= 1'b0;
            else if (sel_i == `RXDT_SEL_TERM50)
                term50_o <= 1'b1;
            else if (is_auto)
                term50_o <= detected_o;
            else
                term50_o <= 1'b0;
        end
    end
endmodule // rxdt_chan
`default_nettype wire

// ---- verification/rxdt_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxdt_top_asserts (
    input wire logic       clock_i,
    input wire logic       sys_rst_i,
    input wire logic       power_down_pin_i,
    input wire logic       management_enable_pin_i,
    input wire logic [1:0] receiver_detect_select_i,
    input wire logic [1:0] signal_detect_threshold_select_i,
    input wire logic [7:0] term50_o,
    input wire logic [7:0] probe_o,
    input wire logic       drivers_enable_o,
    input wire logic [1:0] threshold_code_o,
    input wire logic [7:0] sd_force_o,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // windows cover the two-flop pin sync plus the output register
    a_pd_quiet: assert property (
        power_down_pin_i [*5] |-> term50_o == 8'h00 && probe_o == 8'h00 && !drivers_enable_o)
        else $error("channel active in power-down");
    a_hiz_code: assert property (
        (!management_enable_pin_i && !power_down_pin_i && receiver_detect_select_i == 2'h0) [*6]
        |-> term50_o == 8'h00 && probe_o == 8'h00) else $error("hi-z select not kept");
    a_term_code: assert property (
        (!management_enable_pin_i && !power_down_pin_i && receiver_detect_select_i == 2'h3) [*6]
        |-> term50_o == 8'hff && probe_o == 8'h00) else $error("manual 50 ohm not kept");
    a_probe_pulse: assert property (
        probe_o != 8'h00 |=> probe_o == 8'h00) else $error("probe longer than one cycle");
    a_thresh_map: assert property (
        (!management_enable_pin_i && $stable(signal_detect_threshold_select_i)) [*5]
        |-> threshold_code_o == {signal_detect_threshold_select_i == 2'h0
        || signal_detect_threshold_select_i == 2'h3, signal_detect_threshold_select_i == 2'h1
        || signal_detect_threshold_select_i == 2'h3}) else $error("threshold code wrong");
    a_sdf_clear: assert property (
        !management_enable_pin_i [*5] |-> sd_force_o == 8'h00) else $error("force kept in pin mode");
    a_read_ans: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    a_resp_once: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answered twice");
endmodule // rxdt_top_asserts

bind rxdt_top rxdt_top_asserts u_chk (
    .clock_i, .sys_rst_i, .power_down_pin_i, .management_enable_pin_i,
    .receiver_detect_select_i, .signal_detect_threshold_select_i, .term50_o, .probe_o,
    .drivers_enable_o, .threshold_code_o, .sd_force_o, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// ---- verification/rxdt_link_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxdt_link_partner (
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic [7:0] probe_i,
    input  wire logic [7:0] attach_i,
    input  wire logic       slow_i,
    output wire logic [7:0] present_o
);
    logic [1:0] seen_r;
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seen_r <= 2'h0;
        end else if (!slow_i) begin
            seen_r <= 2'h0;
        end else if (probe_i != 8'h00 && seen_r != 2'h2) begin
            seen_r <= seen_r + 2'h1;
        end
    end
    // load seen late
    // a slow receiver shows its load only after two probes
    assign present_o = (slow_i && seen_r != 2'h2) ? 8'h00 : attach_i;
endmodule // rxdt_link_partner
`default_nettype wire

// ---- verification/rxdt_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rxdt_regs.vh"
module rxdt_top_tb;
    logic        clock_i, sys_rst_i, power_down_pin_i, management_enable_pin_i, slow;
    logic [1:0]  receiver_detect_select_i, signal_detect_threshold_select_i;
    logic [7:0]  partner_present_i, term50_o, probe_o, sd_force_o, attach, mask, v;
    logic        drivers_enable_o;
    logic [1:0]  threshold_code_o, s_axi_bresp, s_axi_rresp;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [34:0] exp_q[$];
    logic [34:0] ent;
    int          fails = 0, total_checks = 0, cyc = 0;

    rxdt_top #(.TICK_CYCLES(2), .TEST_TICKS(4), .GIVEUP_TICKS(20), .PD_CYCLES(4)) dut (
        .clock_i, .sys_rst_i, .power_down_pin_i, .management_enable_pin_i,
        .receiver_detect_select_i, .signal_detect_threshold_select_i, .partner_present_i,
        .term50_o, .probe_o, .drivers_enable_o, .threshold_code_o, .sd_force_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    rxdt_link_partner u_peer (.clock_i, .sys_rst_i, .probe_i(probe_o), .attach_i(attach),
        .slow_i(slow), .present_o(partner_present_i));

    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic cmp_pin(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_bus(input logic [34:0] exp, input logic [34:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED axi_answer expected %h seen %h", exp, got);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        exp_q.push_back({1'b0, er, 32'h0000_0000});
        @(posedge clock_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge clock_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        exp_q.push_back({1'b1, er, d});
        @(posedge clock_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge clock_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clock_i) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            ent = exp_q.pop_front();
            // data of a refused read carries no meaning
            cmp_bus(ent, {s_axi_rvalid, s_axi_rvalid ? s_axi_rresp : s_axi_bresp,
                (s_axi_rvalid && ent[33:32] == 2'h0) ? s_axi_rdata : 32'h0000_0000});
        end
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    initial begin
        {sys_rst_i, power_down_pin_i, management_enable_pin_i, slow} = 4'h8;
        {receiver_detect_select_i, signal_detect_threshold_select_i} = 4'h0;
        {attach, s_axi_awaddr, s_axi_araddr} = 24'h00_0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        void'($urandom(94722));
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        wt(4);
        mask = 8'($urandom()) | 8'h01;
        for (int i = 0; i < 4; i++) begin
            receiver_detect_select_i <= 2'(i);
            attach <= mask;
            slow <= (i == 2);
            wt(i == 3 ? 6 : 40);
            cmp_pin("term50", i == 0 ? 8'h00 : i == 3 ? 8'hff : mask, term50_o);
        end
        for (int l = 0; l < 4; l++) begin
            signal_detect_threshold_select_i <= 2'(l);
            wt(6);
            cmp_pin("threshold", {6'h00, l == 0 || l == 3, l == 1 || l == 3},
                {6'h00, threshold_code_o});
        end
        $display("test pin_select done");
        receiver_detect_select_i <= 2'h1;
        attach <= 8'h00;
        slow <= 1'b0;
        wt(80);
        attach <= 8'hff;
        wt(30);
        cmp_pin("term50", 8'h00, term50_o);
        axr(`RXDT_ADDR_STATUS, 32'h0000_ff00, 2'h0);
        power_down_pin_i <= 1'b1;
        wt(8);
        cmp_pin("drivers", 8'h00, {7'h00, drivers_enable_o});
        power_down_pin_i <= 1'b0;
        wt(36);
        cmp_pin("term50", 8'hff, term50_o);
        attach <= 8'h00;
        wt(20);
        cmp_pin("term50", 8'hff, term50_o);
        receiver_detect_select_i <= 2'h2;
        wt(80);
        cmp_pin("term50", 8'h00, term50_o);
        attach <= mask;
        wt(36);
        cmp_pin("term50", mask, term50_o);
        $display("test auto_detect done");
        receiver_detect_select_i <= 2'h3;
        management_enable_pin_i <= 1'b1;
        wt(8);
        for (int k = 0; k < 4; k++) begin
            axr(8'(4 * k), k == 1 ? 32'(`RXDT_RECEIVER_DETECT_SELECT_RST) : 32'h0000_0000, 2'h0);
        end
        axr(8'h18, 32'h0000_0000, 2'h2);
        axw(8'h18, 32'hffff_ffff, 2'h2);
        axw(`RXDT_ADDR_RECEIVER_DETECT_SELECT, 32'h0000_0000, 2'h0);
        axw(`RXDT_ADDR_THRESH, 32'h0000_0001, 2'h0);
        wt(6);
        cmp_pin("term50", 8'hff, term50_o);
        axr(`RXDT_ADDR_TERM, 32'h0000_06ff, 2'h0);
        axw(`RXDT_ADDR_CTRL, 32'h0000_0003, 2'h0);
        wt(6);
        cmp_pin("term50", 8'h00, term50_o);
        cmp_pin("threshold", 8'h01, {6'h00, threshold_code_o});
        v = 8'($urandom());
        axw(`RXDT_ADDR_SDFORCE, {24'h00_0000, v}, 2'h0);
        wt(4);
        cmp_pin("sd_force", v, sd_force_o);
        axw(`RXDT_ADDR_SDFORCE, {24'h00_0000, v ^ 8'h01}, 2'h0);
        wt(4);
        cmp_pin("sd_force", v ^ 8'h01, sd_force_o);
        power_down_pin_i <= 1'b1;
        wt(8);
        power_down_pin_i <= 1'b0;
        wt(6);
        axr(`RXDT_ADDR_SDFORCE, {24'h00_0000, v ^ 8'h01}, 2'h0);
        management_enable_pin_i <= 1'b0;
        wt(6);
        cmp_pin("sd_force", 8'h00, sd_force_o);
        management_enable_pin_i <= 1'b1;
        wt(6);
        axr(`RXDT_ADDR_SDFORCE, 32'h0000_0000, 2'h0);
        $display("test registers done");
        test_done();
    end
endmodule // rxdt_top_tb
`default_nettype wire
